/* include/brownout_reset_pkg.sv */
// Constants, field layouts and types for the brown-out reset control block
package brownout_reset_pkg;

  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_SOFT     = 2'h1;
  localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
  localparam logic [1:0] MODE_ALWAYS   = 2'h3;

  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_OSC_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_CLOCK_CAL   = 4'h2;
  localparam logic [3:0] ADDR_NVM_CTRL    = 4'h3;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;

  localparam int BIT_POWER_ON   = 0;
  localparam int BIT_LOW_SUPPLY = 1;
  localparam int BIT_SOFT_EN    = 13;

  localparam logic [15:0] RESET_CAUSE_POR = 16'h0003;
  localparam logic [15:0] CLOCK_CAL_RST   = 16'h0000;
  localparam logic [15:0] NVM_CTRL_RST    = 16'h0000;
  localparam logic [2:0]  OSC_FAST_RC     = 3'h0;

  localparam int CLK_MHZ         = 250;
  localparam int POWERUP_DELAY_TIMER_MS         = 64;
  localparam int POWERUP_DELAY_TIMER_CYCLES_DEF = POWERUP_DELAY_TIMER_MS * 1000 * CLK_MHZ;
  localparam int POWERUP_DELAY_TIMER_W          = 25;
  // Cycles spent in power-on before release, so every pin filter has settled
  localparam int SYNC_SETTLE     = 4;

  typedef struct packed {
    logic [1:0] mode;       // supply_monitor_mode
    logic [1:0] threshold;  // supply_threshold_select
    logic       pwrtEn;
    logic       dsEn;       // deep_sleep_monitor_enable
    logic [2:0] initOsc;    // initial_osc_select_fuse
    logic       fscmEn;
  } fuse_cfg_t;

  typedef enum logic [1:0] {
    ST_POR   = 2'b00,
    ST_LOW   = 2'b01,
    ST_DELAY = 2'b10,
    ST_RUN   = 2'b11
  } seq_state_t;

endpackage : brownout_reset_pkg

/* design/brownout_reset_control.sv */
// Brown-out reset sequencer, reset-cause and reset-type-dependent registers
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module brownout_reset_control
  import brownout_reset_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_CYCLES_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire fuse_cfg_t   fuses,
  input  wire logic        supplyBelow,
  input  wire logic        supplyBelowPor,
  input  wire logic        sleepActive,
  input  wire logic        deepSleepExit,
  input  wire logic        clockValid,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [15:0]      rdData,
  output logic             systemResetOut,
  output logic             monitorActive,
  output logic [1:0]       thresholdOut,
  output logic             fastRcSwitch,
  output logic             clockFailTrap,
  output logic             deepSleepMonitorOn
);

  // Pin inputs pass three flops; a change counts once stage 2 and 3 agree.
  // Index 0 supply low, 1 below power-on level, 2 clock source valid.
  localparam int N_PIN = 3;

  logic [N_PIN-1:0] pinRaw;
  logic [N_PIN-1:0] pinFilt;
  logic             lowF_q;
  logic             porF_q;
  logic             clkF_q;

  assign pinRaw = {clockValid, supplyBelowPor, supplyBelow};

  for (genvar i = 0; i < N_PIN; i++) begin : g_pin
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       filt_q;
    logic       filt_d;

    // A one-cycle disagreement holds the last agreed level, so a glitch
    // that meets only one stage never reaches the sequencer
    always_comb begin
      sync_d = {sync_q[1:0], pinRaw[i]};
      filt_d = (sync_q[2] == sync_q[1]) ? sync_q[2] : filt_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        sync_q <= 3'h0;
        filt_q <= 1'b0;
      end else begin
        sync_q <= sync_d;
        filt_q <= filt_d;
      end
    end

    assign pinFilt[i] = filt_q;
  end : g_pin

  assign lowF_q = pinFilt[0];
  assign porF_q = pinFilt[1];
  assign clkF_q = pinFilt[2];

  // Register state
  seq_state_t        state_q;
  seq_state_t        state_d;
  logic [POWERUP_DELAY_TIMER_W-1:0] cnt_q;
  logic [POWERUP_DELAY_TIMER_W-1:0] cnt_d;
  logic              porFlag_q;
  logic              porFlag_d;
  logic              lowFlag_q;
  logic              lowFlag_d;
  logic              softEn_q;
  logic              softEn_d;
  logic [12:0]       otherCause_q;
  logic [12:0]       otherCause_d;
  logic [15:0]       oscCtrl_q;
  logic [15:0]       oscCtrl_d;
  logic [15:0]       clockCal_q;
  logic [15:0]       clockCal_d;
  logic [15:0]       nvmCtrl_q;
  logic [15:0]       nvmCtrl_d;
  logic              fscmArmed_q;
  logic              fscmArmed_d;
  logic              trap_q;
  logic              trap_d;
  logic              fastRc_q;
  logic              fastRc_d;
  logic              system_reset_out_q;
  logic              system_reset_out_d;
  logic              monAct_q;
  logic              monAct_d;
  logic [15:0]       rd_q;
  logic [15:0]       rd_d;
  logic              monEn;
  logic              softVis;
  logic              porEvent;
  logic              borEvent;

  // Mode 01 hands control to software; 10 masks in sleep; 11 never masks
  always_comb begin
    unique case (fuses.mode)
      MODE_OFF: begin
        monEn = 1'b0;
      end
      MODE_SOFT: begin
        monEn = softEn_q;
      end
      MODE_NO_SLEEP: begin
        monEn = !sleepActive;
      end
      MODE_ALWAYS: begin
        monEn = 1'b1;
      end
    endcase
    softVis  = (fuses.mode == MODE_SOFT) && softEn_q;
    // Deep-sleep monitor keeps power-on detection armed
    porEvent = porF_q && (fuses.dsEn || !sleepActive);
    borEvent = monEn && lowF_q && !porEvent;
  end

  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    porFlag_d    = porFlag_q;
    lowFlag_d    = lowFlag_q;
    softEn_d     = softEn_q;
    otherCause_d = otherCause_q;
    oscCtrl_d    = oscCtrl_q;
    clockCal_d   = clockCal_q;
    nvmCtrl_d    = nvmCtrl_q;
    fscmArmed_d  = fscmArmed_q;
    trap_d       = 1'b0;
    fastRc_d     = fastRc_q;
    // Flags: software write first, hardware sets afterwards so a set wins
    if (wrStb) begin
      unique case (addr)
        ADDR_RESET_CAUSE: begin
          porFlag_d    = wrData[BIT_POWER_ON];
          lowFlag_d    = wrData[BIT_LOW_SUPPLY];
          softEn_d     = wrData[BIT_SOFT_EN];
          otherCause_d = {wrData[15:14], wrData[12:2]};
        end
        ADDR_OSC_CTRL: begin
          oscCtrl_d = wrData;
        end
        ADDR_CLOCK_CAL: begin
          clockCal_d = wrData;
        end
        ADDR_NVM_CTRL: begin
          nvmCtrl_d = wrData;
        end
        default: begin
          // Status is read-only; unmapped addresses drop the write
        end
      endcase
    end
    if (deepSleepExit) begin
      porFlag_d = 1'b1;
      lowFlag_d = 1'b1;
    end
    unique case (state_q)
      ST_POR: begin
        // Costs a few cycles per power-on, but the clock check that follows
        // release then sees a settled filter instead of its reset level
        if (porF_q) begin
          cnt_d = '0;
        end else if (cnt_q == POWERUP_DELAY_TIMER_W'(SYNC_SETTLE - 1)) begin
          state_d   = fuses.pwrtEn ? ST_DELAY : ST_RUN;
          cnt_d     = '0;
          oscCtrl_d = {1'b0, fuses.initOsc, 12'h000};
        end else begin
          cnt_d = cnt_q + POWERUP_DELAY_TIMER_W'(1);
        end
      end
      ST_LOW: begin
        if (!lowF_q || !monEn) begin
          state_d = fuses.pwrtEn ? ST_DELAY : ST_RUN;
          cnt_d   = '0;
        end
      end
      ST_DELAY: begin
        if (cnt_q == POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q + POWERUP_DELAY_TIMER_W'(1);
        end
      end
      ST_RUN: begin
        // Check the clock once on release; missing clock falls back to RC
        if (fscmArmed_q && fuses.fscmEn) begin
          fscmArmed_d = 1'b0;
          if (!clkF_q) begin
            fastRc_d = 1'b1;
            trap_d   = 1'b1;
            oscCtrl_d[14:12] = OSC_FAST_RC;
          end
        end
      end
    endcase
    if (porEvent) begin
      state_d = ST_POR;
      cnt_d   = '0;
    end else if (borEvent && state_q != ST_POR) begin
      state_d = ST_LOW;
      cnt_d   = '0;
    end
    // Reset-type-dependent loads; other registers are untouched
    if (porEvent) begin
      clockCal_d   = CLOCK_CAL_RST;
      nvmCtrl_d    = NVM_CTRL_RST;
      otherCause_d = '0;
      softEn_d     = 1'b0;
    end
    if ((porEvent || borEvent) && state_q == ST_RUN) begin
      oscCtrl_d   = {1'b0, fuses.initOsc, 12'h000};
      fscmArmed_d = 1'b1;
      fastRc_d    = 1'b0;
    end else if (state_q == ST_RUN && state_d != ST_RUN) begin
      fscmArmed_d = 1'b1;
    end
    // Hardware sets come last so they win over a same-cycle software clear
    if (porEvent) begin
      porFlag_d = 1'b1;
    end
    if (porEvent || (borEvent && monEn)) begin
      lowFlag_d = 1'b1;
    end
  end

  always_comb begin
    system_reset_out_d = (state_d != ST_RUN);
    monAct_d = monEn;
    rd_d     = 16'h0000;
    if (rdStb) begin
      unique case (addr)
        ADDR_RESET_CAUSE: begin
          rd_d = {otherCause_q[12:11], softVis, otherCause_q[10:0],
                  lowFlag_q, porFlag_q};
        end
        ADDR_OSC_CTRL: begin
          rd_d = oscCtrl_q;
        end
        ADDR_CLOCK_CAL: begin
          rd_d = clockCal_q;
        end
        ADDR_NVM_CTRL: begin
          rd_d = nvmCtrl_q;
        end
        ADDR_STATUS: begin
          rd_d = {12'h000, fuses.threshold, monEn, system_reset_out_q};
        end
        default: begin
          rd_d = 16'h0000;
        end
      endcase
    end
  end

  // Sequencer and the reset output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_POR;
      cnt_q    <= '0;
      system_reset_out_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      system_reset_out_q <= system_reset_out_d;
    end
  end

  // Reset-cause flags; the block's own reset counts as a power-on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      porFlag_q    <= 1'b1;
      lowFlag_q    <= 1'b1;
      softEn_q     <= 1'b0;
      otherCause_q <= '0;
    end else begin
      porFlag_q    <= porFlag_d;
      lowFlag_q    <= lowFlag_d;
      softEn_q     <= softEn_d;
      otherCause_q <= otherCause_d;
    end
  end

  // Software registers; the oscillator field is loaded on leaving power-on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscCtrl_q  <= 16'h0000;
      clockCal_q <= CLOCK_CAL_RST;
      nvmCtrl_q  <= NVM_CTRL_RST;
    end else begin
      oscCtrl_q  <= oscCtrl_d;
      clockCal_q <= clockCal_d;
      nvmCtrl_q  <= nvmCtrl_d;
    end
  end

  // Clock monitor state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fscmArmed_q <= 1'b1;
      trap_q      <= 1'b0;
      fastRc_q    <= 1'b0;
    end else begin
      fscmArmed_q <= fscmArmed_d;
      trap_q      <= trap_d;
      fastRc_q    <= fastRc_d;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      monAct_q <= 1'b0;
      rd_q     <= 16'h0000;
    end else begin
      monAct_q <= monAct_d;
      rd_q     <= rd_d;
    end
  end

  // Threshold is a fuse pass-through, registered; no write path exists
  logic [1:0] thr_q;
  logic [1:0] thr_d;
  logic       ds_q;
  logic       ds_d;

  always_comb begin
    thr_d = fuses.threshold;
    ds_d  = fuses.dsEn;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= 2'h0;
      ds_q  <= 1'b0;
    end else begin
      thr_q <= thr_d;
      ds_q  <= ds_d;
    end
  end

  assign rdData             = rd_q;
  assign systemResetOut     = system_reset_out_q;
  assign monitorActive      = monAct_q;
  assign thresholdOut       = thr_q;
  assign fastRcSwitch       = fastRc_q;
  assign clockFailTrap      = trap_q;
  assign deepSleepMonitorOn = ds_q;

endmodule : brownout_reset_control
`default_nettype wire

/* tb/brownout_reset_monitor.sv */
// Port-level assertions for the brown-out reset control block
`timescale 1ns/1ps
`default_nettype none
module brownout_reset_monitor
  import brownout_reset_pkg::*;
#(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = 16
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire fuse_cfg_t   fuses,
  input wire logic        supplyBelow,
  input wire logic        supplyBelowPor,
  input wire logic        sleepActive,
  input wire logic        deepSleepExit,
  input wire logic        clockValid,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wrData,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [15:0] rdData,
  input wire logic        systemResetOut,
  input wire logic        monitorActive,
  input wire logic [1:0]  thresholdOut,
  input wire logic        fastRcSwitch,
  input wire logic        clockFailTrap,
  input wire logic        deepSleepMonitorOn
);
  int unsigned upCnt_q;
  // Length of each reset-held stretch, to bound the power-up extension
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) upCnt_q <= 0;
    else upCnt_q <= systemResetOut ? upCnt_q + 1 : 0;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Long enough for the three-flop supply synchronisers to settle
  sequence supplyQuiet;
    (!supplyBelow && !supplyBelowPor && !systemResetOut)[*4];
  endsequence

  rd_idle_a: assert property (!$past(rdStb) |-> rdData == 16'h0000)
    else $error("read data outside read slot");
  thr_copy_a: assert property ($past(rst_n) && $stable(fuses.threshold) |=>
    thresholdOut == $past(fuses.threshold)) else $error("threshold not from fuse");
  mon_off_a: assert property ((fuses.mode == MODE_OFF)[*3] |-> !monitorActive)
    else $error("monitor on in mode 00");
  mon_on_a: assert property ((fuses.mode == MODE_ALWAYS)[*3] |-> monitorActive)
    else $error("monitor off in mode 11");
  sleep_off_a: assert property ((fuses.mode == MODE_NO_SLEEP && sleepActive)[*3]
    |-> !monitorActive) else $error("monitor on in sleep");
  wake_on_a: assert property ((fuses.mode == MODE_NO_SLEEP && !sleepActive)[*3]
    |-> monitorActive) else $error("monitor off when awake");
  bor_hold_a: assert property ((monitorActive && supplyBelow)[*7] |-> systemResetOut)
    else $error("no reset on low supply");
  powerup_delay_timer_len_a: assert property ($fell(systemResetOut) && fuses.pwrtEn |->
    upCnt_q >= POWERUP_DELAY_TIMER_CYCLES) else $error("power-up extension too short");
  trap_pulse_a: assert property (clockFailTrap |=> !clockFailTrap)
    else $error("trap longer than one cycle");
  trap_rc_a: assert property (clockFailTrap |=> fastRcSwitch)
    else $error("trap without internal RC switch");
  trap_run_a: assert property (clockFailTrap |-> !systemResetOut)
    else $error("clock check during reset");
  sw_flag_a: assert property (supplyQuiet ##0 (wrStb && addr == ADDR_RESET_CAUSE)
    |=> !systemResetOut) else $error("flag write caused reset");
endmodule : brownout_reset_monitor

bind brownout_reset_control brownout_reset_monitor #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) mon_u (
  .ref_clk, .rst_n, .fuses, .supplyBelow, .supplyBelowPor, .sleepActive, .deepSleepExit,
  .clockValid, .addr, .wrData, .wrStb, .rdStb, .rdData, .systemResetOut, .monitorActive,
  .thresholdOut, .fastRcSwitch, .clockFailTrap, .deepSleepMonitorOn);
`default_nettype wire

/* tb/brownout_reset_control_tb.sv */
// Self-checking bench for the brown-out reset control block
`timescale 1ns/1ps
`default_nettype none
module brownout_reset_control_tb
  import brownout_reset_pkg::*;
;
  localparam int P = 16;
  logic        ref_clk = 0, rst_n = 0, supplyBelow = 0, supplyBelowPor = 0, seen;
  logic        sleepActive = 0, deepSleepExit = 0, clockValid = 1, wrStb = 0, rdStb = 0;
  fuse_cfg_t   fuses = '0;
  logic [3:0]  addr = '0;
  logic [15:0] wrData = '0, rdData, cal, v;
  logic        systemResetOut, monitorActive, fastRcSwitch, clockFailTrap, deepSleepMonitorOn;
  logic [1:0]  thresholdOut;
  int          err_total = 0, n_checks = 0, cyc = 0, seed = 32'h4d6e65af, cnt;

  brownout_reset_control #(.POWERUP_DELAY_TIMER_CYCLES(P)) dut_u (
    .ref_clk, .rst_n, .fuses, .supplyBelow, .supplyBelowPor, .sleepActive, .deepSleepExit,
    .clockValid, .addr, .wrData, .wrStb, .rdStb, .rdData, .systemResetOut, .monitorActive,
    .thresholdOut, .fastRcSwitch, .clockFailTrap, .deepSleepMonitorOn);

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wrStb <= 1;
    addr <= a;
    wrData <= d;
    @(posedge ref_clk);
    wrStb <= 0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    rdStb <= 1;
    addr <= a;
    @(posedge ref_clk);
    rdStb <= 0;
    #1 v = rdData;
  endtask : rd

  // Bounded wait, so a reset that never lifts cannot hang the run
  task waitUp;
    cnt = 0;
    while (systemResetOut !== 1'b0 && cnt < 200) begin
      @(posedge ref_clk);
      #1 cnt++;
    end
  endtask : waitUp

  // Fuses only change under reset, since they are static in silicon
  task por(input int m);
    @(posedge ref_clk);
    rst_n <= 0;
    fuses <= '{mode: m[1:0], threshold: 2'($random(seed)), pwrtEn: m[0], dsEn: m[1],
               initOsc: 3'($random(seed)), fscmEn: 1'b1};
    clockValid <= (m != 2);
    repeat (6) @(posedge ref_clk);
    rst_n <= 1;
    #1 waitUp();
    chk("delay", 16'(m[0]), 16'(cnt >= P));
    clockValid <= 1;
  endtask : por

  task brown(input logic sl);
    @(posedge ref_clk);
    sleepActive <= sl;
    supplyBelow <= 1;
    repeat (12) @(posedge ref_clk);
    #1 seen = systemResetOut;
    supplyBelow <= 0;
    // Wake only once the filtered supply is good again, so no late trip
    repeat (6) @(posedge ref_clk);
    sleepActive <= 0;
    waitUp();
  endtask : brown

  initial begin
    for (int m = 0; m < 4; m++) begin
      por(m);
      chk("thr", 16'(fuses.threshold), 16'(thresholdOut));
      chk("dsm", 16'(fuses.dsEn), 16'(deepSleepMonitorOn));
      rd(ADDR_RESET_CAUSE);
      chk("cause", RESET_CAUSE_POR, v & 16'h0003);
      rd(ADDR_OSC_CTRL);
      chk("osc", 16'(m == 2 ? OSC_FAST_RC : fuses.initOsc), 16'(v[14:12]));
      chk("fast", 16'(m == 2), 16'(fastRcSwitch));
      cal = 16'($random(seed));
      wr(ADDR_CLOCK_CAL, cal);
      wr(ADDR_STATUS, 16'hffff);
      wr(ADDR_RESET_CAUSE, 16'h2000);
      rd(ADDR_RESET_CAUSE);
      chk("soft", 16'(m == 1) << 13, v);
      if (m == 2) begin
        brown(1);
        chk("sleep", 16'h0000, 16'(seen));
      end
      brown(0);
      chk("bor", 16'(m != 0), 16'(seen));
      rd(ADDR_RESET_CAUSE);
      chk("flag", (16'(m == 1) << 13) | (16'(m != 0) << 1), v);
      rd(ADDR_CLOCK_CAL);
      chk("cal", cal, v);
      rd(ADDR_STATUS);
      chk("stat", {12'h000, fuses.threshold, m != 0, 1'b0}, v);
      wr(ADDR_RESET_CAUSE, 16'h0000);
      brown(0);
      chk("off", 16'(m > 1), 16'(seen));
      wr(ADDR_RESET_CAUSE, 16'h0000);
      @(posedge ref_clk);
      deepSleepExit <= 1;
      @(posedge ref_clk);
      deepSleepExit <= 0;
      rd(ADDR_RESET_CAUSE);
      chk("deep", 16'h0003, v & 16'h0003);
      rd(4'hf);
      chk("hole", 16'h0000, v);
    end
    final_report();
  end
endmodule : brownout_reset_control_tb
`default_nettype wire
